// ==== logic/rts_pkg.sv ====
// How it works
// (R1) Record six distinct reset causes
// (R2) Unaffected registers survive all non power-on resets
// (R3) Other registers reload, except on watchdog wake
// (R4) Expired and sleep flags encode the cause
// (R5) Filter discards short master-clear pulses
// (R6) Watchdog reset never drives the pin
// (R7) Power-on detector starts a power-on reset
// (R8) Power-up delay 72 ms, power-on and supply-drop only
// (R9) Core held in reset during power-up delay
// (R10) Enable setting gates the power-up delay
// (R11) Settle timer counts 1024 oscillator edges
// (R12) Settle only crystal modes, power-on or wake
// (R13) Enable setting turns supply-drop reset on
// (R14) Drop longer than minimum duration resets
// (R15) Hold until recovery, then power-up delay
// (R16) New drop during delay restarts sequence
// (R17) Supply-drop enable forces the power-up delay
// (R18) Release only after delay and settle finish
// (R19) Held master-clear releases core immediately
// (R20) Two-bit field picks one of four modes
// (R21) Power-on flag cleared only by power-on
// (R22) Supply-drop flag cleared by supply-drop reset
// (R23) Delay, drop and filter lengths are parameters
package rts_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_KHZ = 50_000;
  localparam int POWER_UP_DELAY_TIMER_MS = 72;
  localparam int DROP_US = 100;
  localparam int MASTER_CLEAR_PIN_FILT_NS = 200;
  localparam int POWER_UP_DELAY_TIMER_CYCLES = POWER_UP_DELAY_TIMER_MS * CLK_KHZ;
  localparam int DROP_CYCLES = (DROP_US * CLK_KHZ + 999) / 1000;
  localparam int MASTER_CLEAR_PIN_FILT_CYCLES = (MASTER_CLEAR_PIN_FILT_NS * CLK_KHZ) / 1_000_000;
  localparam int OST_EDGES = 1024;
  localparam int CNT_W = 32;
  localparam int OST_W = 11;
  localparam int FILT_W = 8;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] OFF_CONFIG = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_CORE_CTRL = 12'h008;
  localparam logic [11:0] OFF_SCRATCH = 12'h00c;
  localparam logic [31:0] CORE_CTRL_RST = 32'h0000_0000;
  localparam int STAT_PFLAG_BIT = 1;
  localparam int STAT_DFLAG_BIT = 0;

  typedef enum logic [1:0] {
    OSC_LOW_POWER, OSC_MID, OSC_HIGH_SPEED, OSC_RES_CAP
  } rts_osc_e;

  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_POWER_ON, CAUSE_MASTER_CLEAR_PIN_RUN, CAUSE_MASTER_CLEAR_PIN_SLEEP,
    CAUSE_WDT_RESET, CAUSE_WDT_WAKE, CAUSE_SUPPLY_DROP
  } rts_cause_e;

  typedef enum logic [2:0] {
    SEQ_POWER_UP_DELAY_TIMER, SEQ_DROP, SEQ_OST, SEQ_WAKE, SEQ_RUN
  } rts_seq_e;

  // Config word: [3:2] mode, [1] drop enable, [0] delay enable
  typedef struct packed {
    rts_osc_e clock_source_select;
    logic supply_drop_enable;
    logic power_up_delay_enable;
  } rts_cfg_s;

  localparam rts_cfg_s CFG_RST = '{OSC_MID, 1'b0, 1'b1};

  // Status word, high bits first as listed down to bit 0
  typedef struct packed {
    logic master_clear_pin_low;
    logic seq_busy;
    logic core_reset;
    rts_cause_e cause;
    logic sleep_entered_flag;
    logic watchdog_expired_flag;
    logic power_on_flag;
    logic supply_drop_flag;
  } rts_stat_s;

endpackage : rts_pkg

// ==== logic/rts_sequencer.sv ====
`timescale 1ns/1ps
module rts_sequencer #(
  parameter int POWER_UP_DELAY_TIMER_LEN = rts_pkg::POWER_UP_DELAY_TIMER_CYCLES,
  parameter int DROP_LEN = rts_pkg::DROP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources and oscillator input
  input wire logic master_clear_pin_n,
  input wire logic por_detect,
  input wire logic supply_low,
  input wire logic osc_input_pin,
  // Watchdog and core events
  input wire logic wdt_timeout,
  input wire logic wdt_clear,
  input wire logic sleep_cmd,
  // Core side
  output logic core_reset,
  output logic core_wake,
  output logic core_sleeping,
  output logic [31:0] core_ctrl,
  output logic [31:0] scratch
);
  import rts_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic [3:0] reg_sel(input logic [11:0] a);
    reg_sel = {a == OFF_SCRATCH, a == OFF_CORE_CTRL,
               a == OFF_STATUS, a == OFF_CONFIG};
  endfunction : reg_sel

  wire logic [3:0] sel_w = reg_sel(paddr);
  wire logic hit_w = |sel_w;
  wire logic setup_w = psel & ~penable;
  wire logic acc_w = psel & penable;
  wire logic wr_w = acc_w & pwrite & hit_w;

  rts_cfg_s cfg_q;
  rts_seq_e seq_q, seq_d;
  rts_cause_e cause_q;
  logic [CNT_W-1:0] power_up_delay_timer_cnt_q;
  logic [CNT_W-1:0] drop_cnt_q;
  logic [OST_W-1:0] ost_cnt_q;
  logic [FILT_W-1:0] filt_cnt_q;
  logic master_clear_pin_low_q, master_clear_pin_low_prev_q;
  logic por_prev_q, osc_prev_q;
  logic power_up_delay_timer_from_drop_q;
  logic wdt_rst_q;
  logic wake_q;
  logic sleep_q;
  logic to_q, pd_q, pflag_q, dflag_q;
  logic [31:0] prdata_q;
  logic [31:0] core_ctrl_q;
  logic [31:0] scratch_q;

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  // Power-on detector edge starts a fresh power-on reset
  wire logic por_ev = por_detect & ~por_prev_q; // [R7]
  wire logic crystal_w = cfg_q.clock_source_select != OSC_RES_CAP; // [R20]
  wire logic power_up_delay_timer_on_w = cfg_q.power_up_delay_enable
                         | cfg_q.supply_drop_enable; // [R10] [R17]
  wire logic drop_trip = cfg_q.supply_drop_enable
                         & (drop_cnt_q == CNT_W'(DROP_LEN)); // [R13] [R14]
  wire logic power_up_delay_timer_done = power_up_delay_timer_cnt_q == CNT_W'(POWER_UP_DELAY_TIMER_LEN - 1);
  wire logic osc_edge = osc_input_pin & ~osc_prev_q;
  wire logic ost_done = osc_edge
                        & (ost_cnt_q == OST_W'(OST_EDGES - 1)); // [R11]
  wire logic running_w = seq_q == SEQ_RUN;
  wire logic master_clear_pin_fall = master_clear_pin_low_q & ~master_clear_pin_low_prev_q;
  wire logic master_clear_pin_ev = master_clear_pin_fall & (running_w | seq_q == SEQ_WAKE);
  wire logic wdt_rst_ev = wdt_timeout & running_w & ~sleep_q
                          & ~master_clear_pin_low_q;
  wire logic wdt_wake_ev = wdt_timeout & running_w & sleep_q
                           & ~master_clear_pin_low_q;
  wire logic wake_done = (seq_q == SEQ_WAKE) & ost_done;

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      SEQ_POWER_UP_DELAY_TIMER: begin
        if (cfg_q.supply_drop_enable && supply_low) begin
          seq_d = SEQ_DROP; // [R16]
        end else if (!power_up_delay_timer_on_w || power_up_delay_timer_done) begin
          // Drop recovery ends here; power-on in crystal modes goes on to settle
          if (crystal_w && !power_up_delay_timer_from_drop_q) begin
            seq_d = SEQ_OST; // [R11] [R12]
          end else begin
            seq_d = SEQ_RUN;
          end
        end
      end
      SEQ_DROP: begin
        if (!supply_low) begin
          seq_d = SEQ_POWER_UP_DELAY_TIMER; // [R15]
        end
      end
      SEQ_OST: begin
        if (ost_done) begin
          seq_d = SEQ_RUN; // [R18]
        end
      end
      SEQ_WAKE: begin
        if (ost_done || master_clear_pin_ev) begin
          seq_d = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (wdt_wake_ev && crystal_w) begin
          seq_d = SEQ_WAKE; // [R12]
        end
      end
      default: begin
        seq_d = SEQ_POWER_UP_DELAY_TIMER;
      end
    endcase
    // Power-on and a qualified drop override any state
    if (por_ev) begin
      seq_d = SEQ_POWER_UP_DELAY_TIMER; // [R8]
    end else if (drop_trip) begin
      seq_d = SEQ_DROP; // [R14]
    end
  end

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= SEQ_POWER_UP_DELAY_TIMER;
      power_up_delay_timer_from_drop_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      if (por_ev) begin
        power_up_delay_timer_from_drop_q <= 1'b0;
      end else if (seq_d == SEQ_DROP) begin
        power_up_delay_timer_from_drop_q <= 1'b1;
      end
    end
  end

  // Delay counter restarts on every entry to the delay state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_up_delay_timer_cnt_q <= '0;
    end else if (seq_q != SEQ_POWER_UP_DELAY_TIMER || seq_d != SEQ_POWER_UP_DELAY_TIMER) begin
      power_up_delay_timer_cnt_q <= '0;
    end else begin
      power_up_delay_timer_cnt_q <= power_up_delay_timer_cnt_q + CNT_W'(1); // [R8] [R23]
    end
  end

  // Settle counter counts rising edges of the oscillator input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_cnt_q <= '0;
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_input_pin;
      if (seq_q != SEQ_OST && seq_q != SEQ_WAKE) begin
        ost_cnt_q <= '0;
      end else if (osc_edge) begin
        ost_cnt_q <= ost_cnt_q + OST_W'(1); // [R11]
      end
    end
  end

  // Drop duration counter saturates so the trip is one level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_cnt_q <= '0;
    end else if (!supply_low || !cfg_q.supply_drop_enable) begin
      drop_cnt_q <= '0; // [R14]
    end else if (drop_cnt_q != CNT_W'(DROP_LEN)) begin
      drop_cnt_q <= drop_cnt_q + CNT_W'(1); // [R23]
    end
  end

  // ----------------------------------------
  // Master-clear filter
  // ----------------------------------------
  // Level only follows the pin after it has been stable a while
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_clear_pin_low_q <= 1'b0;
      master_clear_pin_low_prev_q <= 1'b0;
      filt_cnt_q <= '0;
      por_prev_q <= 1'b0;
    end else begin
      master_clear_pin_low_prev_q <= master_clear_pin_low_q;
      por_prev_q <= por_detect;
      if (master_clear_pin_n != master_clear_pin_low_q) begin
        filt_cnt_q <= '0;
      end else if (filt_cnt_q == FILT_W'(MASTER_CLEAR_PIN_FILT_CYCLES - 1)) begin
        filt_cnt_q <= '0;
        master_clear_pin_low_q <= ~master_clear_pin_n; // [R5] [R23]
      end else begin
        filt_cnt_q <= filt_cnt_q + FILT_W'(1);
      end
    end
  end

  // ----------------------------------------
  // Core reset and wake
  // ----------------------------------------
  // Watchdog reset is internal only; no pin drive exists here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_rst_q <= 1'b0;
      wake_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      wdt_rst_q <= wdt_rst_ev; // [R6]
      wake_q <= wake_done | (wdt_wake_ev & ~crystal_w);
      if (core_reset || wake_q || master_clear_pin_ev) begin
        sleep_q <= 1'b0;
      end else if (sleep_cmd && running_w) begin
        sleep_q <= 1'b1;
      end
    end
  end

  // Held pin overrides timeouts, so release follows the pin
  assign core_reset = (seq_q != SEQ_RUN && seq_q != SEQ_WAKE)
                      | master_clear_pin_low_q | wdt_rst_q; // [R9] [R18] [R19]
  assign core_wake = wake_q;
  assign core_sleeping = sleep_q;

  // ----------------------------------------
  // Cause and status flags
  // ----------------------------------------
  // Hardware events beat a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= CAUSE_POWER_ON;
      to_q <= 1'b1;
      pd_q <= 1'b1;
      pflag_q <= 1'b0;
      dflag_q <= 1'b0;
    end else if (por_ev) begin
      cause_q <= CAUSE_POWER_ON; // [R1]
      to_q <= 1'b1; // [R4]
      pd_q <= 1'b1;
      pflag_q <= 1'b0; // [R21]
    end else if (drop_trip && seq_q != SEQ_DROP) begin
      cause_q <= CAUSE_SUPPLY_DROP; // [R1]
      to_q <= 1'b1; // [R4]
      pd_q <= 1'b1;
      dflag_q <= 1'b0; // [R22]
    end else if (master_clear_pin_ev) begin
      cause_q <= sleep_q ? CAUSE_MASTER_CLEAR_PIN_SLEEP : CAUSE_MASTER_CLEAR_PIN_RUN; // [R1]
      if (sleep_q) begin
        to_q <= 1'b1; // [R4]
        pd_q <= 1'b0;
      end
    end else if (wdt_rst_ev) begin
      cause_q <= CAUSE_WDT_RESET; // [R1]
      to_q <= 1'b0; // [R4]
      pd_q <= 1'b1;
    end else if (wdt_wake_ev) begin
      cause_q <= CAUSE_WDT_WAKE; // [R1]
      to_q <= 1'b0; // [R4]
      pd_q <= 1'b0;
    end else begin
      if (sleep_cmd && running_w && !core_reset) begin
        to_q <= 1'b1;
        pd_q <= 1'b0;
      end else if (wdt_clear && !core_reset) begin
        to_q <= 1'b1;
        pd_q <= 1'b1;
      end
      if (wr_w && sel_w[1] && pwdata[STAT_PFLAG_BIT]) begin
        pflag_q <= 1'b1;
      end
      if (wr_w && sel_w[1] && pwdata[STAT_DFLAG_BIT]) begin
        dflag_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  // Config survives core resets; it stands in for fuse bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RST;
    end else if (wr_w && sel_w[0]) begin
      cfg_q <= rts_cfg_s'(pwdata[3:0]); // [R20]
    end
  end

  // Ordinary register: reloads on every reset except a wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ctrl_q <= CORE_CTRL_RST;
    end else if (core_reset) begin
      core_ctrl_q <= CORE_CTRL_RST; // [R3]
    end else if (wr_w && sel_w[2]) begin
      core_ctrl_q <= pwdata;
    end
  end

  // Unaffected register: no reset, so it starts unknown
  always_ff @(posedge pclk) begin
    if (wr_w && sel_w[3]) begin
      scratch_q <= pwdata; // [R2]
    end
  end

  assign core_ctrl = core_ctrl_q;
  assign scratch = scratch_q;

  // ----------------------------------------
  // APB read path
  // ----------------------------------------
  wire rts_stat_s stat_w = '{master_clear_pin_low_q, ~running_w, core_reset,
                             cause_q, pd_q, to_q, pflag_q, dflag_q};
  wire logic [31:0] rd_w = sel_w[0] ? 32'(cfg_q) :
                           sel_w[1] ? 32'(stat_w) :
                           sel_w[2] ? core_ctrl_q :
                           sel_w[3] ? scratch_q : 32'h0000_0000;

  // Read data is captured in the setup cycle, valid in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_w) begin
      prdata_q <= rd_w;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = acc_w & ~hit_w;

endmodule : rts_sequencer

// ==== verif/rts_chk.sv ====
`timescale 1ns/1ps
module rts_chk #(
  parameter int POWER_UP_DELAY_TIMER_LEN = 20,
  parameter int DROP_LEN = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic master_clear_pin_n,
  input wire logic por_detect,
  input wire logic supply_low,
  input wire logic wdt_timeout,
  input wire logic core_reset,
  input wire logic core_wake,
  input wire logic core_sleeping,
  input wire logic [31:0] core_ctrl
);
  // ------------------------------
  // Run lengths and config shadow
  // ------------------------------
  logic [7:0] low_q;
  logic [7:0] drop_q;
  logic [3:0] cfg_q;
  // Saturating, so a long hold never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q <= 8'h00;
      drop_q <= 8'h00;
      cfg_q <= 4'h5;
    end else begin
      low_q <= master_clear_pin_n ? 8'h00 : low_q + 8'(low_q != 8'hff);
      drop_q <= supply_low ? drop_q + 8'(drop_q != 8'hff) : 8'h00;
      if (psel && penable && pready && pwrite && paddr == 12'h000)
        cfg_q <= pwdata[3:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_slverr_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("error response outside access");
  a_unmapped_rd: assert property (psel && penable && paddr >= 12'h010
    |-> pslverr && prdata == 32'h0) else $error("unmapped access");
  a_ctrl_clear: assert property (core_reset |=> core_ctrl == 32'h0)
    else $error("control word kept in reset");
  a_wake_once: assert property (core_wake |=> !core_wake)
    else $error("wake pulse too long");
  a_pin_hold: assert property (low_q >= 8'd14 |-> core_reset)
    else $error("long pin low without reset");
  a_pin_release: assert property ($fell(core_reset) |-> low_q < 8'd11)
    else $error("release while pin low");
  a_por_hold: assert property ($rose(por_detect) |-> ##2 core_reset[*8])
    else $error("power-on did not hold reset");
  a_wdt_reset: assert property (wdt_timeout && !core_sleeping && !core_reset
    && master_clear_pin_n |-> ##[1:2] core_reset)
    else $error("watchdog reset missing");
  a_drop_reset: assert property (cfg_q[1] && drop_q == DROP_LEN + 2
    |-> ##[0:2] core_reset) else $error("no supply-drop reset");
  a_drop_hold: assert property (cfg_q[1] && core_reset && $fell(supply_low)
    |-> core_reset[*8]) else $error("no delay after drop");

  c_release: cover property ($fell(core_reset));
  c_wake: cover property (core_wake);
  c_slverr: cover property (pslverr);
endmodule : rts_chk

bind rts_sequencer rts_chk #(.POWER_UP_DELAY_TIMER_LEN(POWER_UP_DELAY_TIMER_LEN), .DROP_LEN(DROP_LEN)) chk_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .master_clear_pin_n, .por_detect, .supply_low,
  .wdt_timeout, .core_reset, .core_wake, .core_sleeping, .core_ctrl
);

// ==== verif/rts_far_end.sv ====
`timescale 1ns/1ps
module rts_far_end (
  input wire logic osc_en,
  input wire logic por_req,
  input wire logic drop_req,
  input wire logic pin_low_req,
  output logic por_detect,
  output logic supply_low,
  output logic master_clear_pin_n,
  output logic osc_input_pin
);
  // Crystal on its own 74 ns time base, unrelated to pclk
  initial begin
    osc_input_pin = 1'b0;
    forever #37 osc_input_pin = osc_en ? ~osc_input_pin : osc_input_pin;
  end
  // Detector and pin levels follow the bench's requests
  assign por_detect = por_req;
  assign supply_low = drop_req;
  assign master_clear_pin_n = !pin_low_req;
endmodule : rts_far_end

// ==== verif/reset_timeout_sequencer_tb.sv ====
`timescale 1ns/1ps
module reset_timeout_sequencer_tb;
  import rts_pkg::*;
  localparam int PW = 20;
  localparam int OSC = 3789; // 1024 edges of the 74 ns crystal
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, core_ctrl, scratch, rd;
  logic por_detect, supply_low, osc_input_pin, master_clear_pin_n;
  logic wdt_timeout, wdt_clear, sleep_cmd, core_reset, core_wake;
  logic core_sleeping, por_req, drop_req, pin_low_req;
  int num_errors, n_checks, n;
  // Stimulus bits, so one task can pulse any of them
  localparam int S_SLP = 0, S_CLR = 1, S_WDT = 2, S_PIN = 3;
  localparam int S_DROP = 4, S_POR = 5;
  logic [5:0] stim;
  assign {por_req, drop_req, pin_low_req, wdt_timeout, wdt_clear,
          sleep_cmd} = stim;

  rts_sequencer #(.POWER_UP_DELAY_TIMER_LEN(PW), .DROP_LEN(8)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .master_clear_pin_n, .por_detect, .supply_low,
    .osc_input_pin, .wdt_timeout, .wdt_clear, .sleep_cmd, .core_reset,
    .core_wake, .core_sleeping, .core_ctrl, .scratch
  );
  rts_far_end far_u (
    .osc_en(1'b1), .por_req, .drop_req, .pin_low_req, .por_detect,
    .supply_low, .master_clear_pin_n, .osc_input_pin
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ------------------------------
  // Bench tasks
  // ------------------------------
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic rng(input int v, input int lo, input int hi);
    check(32'(v >= lo && v <= hi), 32'h1);
  endtask : rng

  // One APB transfer; waits for pready, gives up after 20 edges
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      check(32'h0, 32'h1);
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic hold(input int k, input int c);
    @(posedge pclk);
    stim[k] <= 1'b1;
    repeat (c) @(posedge pclk);
    stim[k] <= 1'b0;
  endtask : hold

  // Bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_sig(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      wrap_up();
    end
  endtask : wait_sig

  // Cause field and the expired/sleep pair of the status word
  task automatic stat(input logic [2:0] c, input logic [1:0] f);
    apb(1'b0, 12'h004, 32'h0);
    check(32'(rd[6:2]), 32'({c, f}));
  endtask : stat

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    stim = '0;
    {num_errors, n_checks} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h5);
    wait_sig(core_reset, 1'b0, 9000);
    rng(n, PW + OSC - 10, PW + OSC + 20);
    stat(3'd1, 2'b11);
    check(32'(rd[1]), 32'h0);
    apb(1'b1, 12'h004, 32'h3);
    apb(1'b1, 12'h00c, 32'ha5a5);
    apb(1'b1, 12'h008, 32'h1234);
    hold(S_PIN, 5);
    repeat (20) @(posedge pclk);
    check(32'(core_reset), 32'h0);
    hold(S_PIN, 40);
    check(32'(core_reset), 32'h1);
    wait_sig(core_reset, 1'b0, 100);
    rng(n, 8, 14);
    stat(3'd2, 2'b11);
    check(32'(rd[1:0]), 32'h3);
    apb(1'b0, 12'h00c, 32'h0);
    check(rd, 32'ha5a5);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 12'h008, 32'h77);
    hold(S_WDT, 1);
    wait_sig(core_reset, 1'b1, 5);
    wait_sig(core_reset, 1'b0, 50);
    stat(3'd4, 2'b10);
    apb(1'b1, 12'h008, 32'h77);
    hold(S_SLP, 1);
    hold(S_WDT, 1);
    wait_sig(core_wake, 1'b1, 9000);
    rng(n, OSC - 10, OSC + 20);
    stat(3'd5, 2'b00);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h77);
    apb(1'b1, 12'h000, 32'he);
    hold(S_CLR, 1);
    stat(3'd5, 2'b11);
    hold(S_SLP, 1);
    hold(S_WDT, 1);
    wait_sig(core_wake, 1'b1, 50);
    rng(n, 0, 4);
    hold(S_DROP, 4);
    repeat (5) @(posedge pclk);
    check(32'(core_reset), 32'h0);
    hold(S_DROP, 30);
    check(32'(core_reset), 32'h1);
    repeat (10) @(posedge pclk);
    hold(S_DROP, 3);
    wait_sig(core_reset, 1'b0, 200);
    rng(n, PW, PW + 10);
    stat(3'd6, 2'b11);
    check(32'(rd[1:0]), 32'h2);
    apb(1'b0, 12'h010, 32'h0);
    check({rd[30:0], err}, 32'h1);
    hold(S_POR, 2);
    wait_sig(core_reset, 1'b0, 9000);
    rng(n, PW - 3, 9000);
    stat(3'd1, 2'b11);
    wrap_up();
  end
endmodule : reset_timeout_sequencer_tb
